// ### design/cis_top.sv
`default_nettype none
// Behaviour
// - Four blocks, each 256-byte cache or 512-byte RAM.
// - RAM block answers at its own base.
// - Cache block: direct-mapped, sixty-four 32-bit words.
// - Cache blocks combine into up to four ways.
// - Locked cache block keeps contents, takes no fill.
// - Block hits proceed while DMA holds bus.
module cis_top
   import cis_pkg::*;
(
   input wire logic ref_clk,                                   // System clock.
   input wire logic srst,                                      // Sync reset, high.
   input wire logic ce,                                        // Clock enable.
   input wire logic [cis_pkg::CIS_NUM_BLOCKS-1:0] cfg_ram,     // Block is RAM.
   input wire logic [cis_pkg::CIS_NUM_BLOCKS-1:0] cfg_lock,    // Block locked.
   input wire logic [cis_pkg::CIS_NUM_BLOCKS*cis_pkg::CIS_ADDR_W-1:0] cfg_base, // RAM bases.
   input wire logic fetch_valid,                               // Fetch request.
   input wire logic [cis_pkg::CIS_ADDR_W-1:0] fetch_addr,      // Fetch address.
   output logic fetch_ready,                                   // Fetch taken.
   output logic resp_valid,                                    // Word returned.
   output logic [cis_pkg::CIS_DATA_W-1:0] resp_data,           // Returned word.
   output logic resp_ext,                                      // Word came off chip.
   input wire logic wr_valid,                                  // RAM load strobe.
   input wire logic [cis_pkg::CIS_ADDR_W-1:0] wr_addr,         // RAM load address.
   input wire logic [cis_pkg::CIS_DATA_W-1:0] wr_data,         // RAM load word.
   output logic ext_req,                                       // External read.
   output logic [cis_pkg::CIS_ADDR_W-1:0] ext_addr,            // External address.
   input wire logic ext_ack,                                   // External word ready.
   input wire logic [cis_pkg::CIS_DATA_W-1:0] ext_rdata        // External word.
);
   // ------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------
   cis_state_t state;                            // Sequencer state.
   logic [CIS_ADDR_W-1:0] look_addr;             // Address shown to blocks.
   logic [CIS_NUM_BLOCKS-1:0] hit_vec;           // Per-block hit.
   logic [CIS_DATA_W-1:0] rd_vec [CIS_NUM_BLOCKS]; // Per-block word.
   logic any_hit;                                // Some block holds the word.
   logic [CIS_BLK_W-1:0] hit_sel;                // Block that answers.
   logic [CIS_NUM_BLOCKS-1:0] fill_ok;           // Ways that may take a fill.
   logic [CIS_BLK_W-1:0] victim;                 // Round-robin pointer.
   logic [CIS_BLK_W-1:0] fill_sel;               // Way chosen for this fill.
   logic fill_now;                               // External word arriving.
   logic take;                                   // Fetch accepted this cycle.

   // ------------------------------------------------------------
   // Helper functions.
   // ------------------------------------------------------------
   // Lowest set bit at or after a starting position, wrapping round.
   function automatic logic [CIS_BLK_W-1:0] cis_pick
   (
      input logic [CIS_NUM_BLOCKS-1:0] vec,
      input logic [CIS_BLK_W-1:0] start
   );
      logic [CIS_BLK_W-1:0] pos;
      logic found;
      pos = start;
      found = 1'b0;
      cis_pick = start;
      for (int i = 0; i < CIS_NUM_BLOCKS; i++)
      begin
         if (!found && vec[pos])
         begin
            cis_pick = pos;
            found = 1'b1;
         end
         pos = pos + CIS_BLK_W'(1);
      end
   endfunction : cis_pick

   // ------------------------------------------------------------
   // Lookup across all blocks.
   // ------------------------------------------------------------
   // The fetch address goes straight to the blocks while idle, so a hit
   // needs no external bus and never waits on DMA traffic there.
   assign look_addr = (state == CIS_IDLE) ? fetch_addr : ext_addr;
   assign any_hit = |hit_vec;
   assign hit_sel = cis_pick(hit_vec, CIS_VICTIM_RST);
   assign fetch_ready = (state == CIS_IDLE);
   assign take = ce && fetch_valid && fetch_ready;
   assign fill_now = ce && (state == CIS_MISS) && ext_ack;
   // Only unlocked cache-mode blocks are candidate ways.
   assign fill_ok = ~cfg_ram & ~cfg_lock;
   assign fill_sel = cis_pick(fill_ok, victim);

   // ------------------------------------------------------------
   // Block instances, one interface each.
   // ------------------------------------------------------------
   generate
      for (genvar g = 0; g < CIS_NUM_BLOCKS; g++)
      begin : g_blk
         cis_blk_if blk_if ();
         // Mode, lock and base are live inputs and may change at any time.
         assign blk_if.addr = wr_valid && (state == CIS_IDLE) && !fetch_valid
                              ? wr_addr : look_addr;
         assign blk_if.mode_ram = cfg_ram[g];
         assign blk_if.lock = cfg_lock[g];
         assign blk_if.base = cfg_base[g*CIS_ADDR_W +: CIS_ADDR_W];
         assign blk_if.fill_we = fill_now && (|fill_ok) &&
                                 (fill_sel == CIS_BLK_W'(g));
         assign blk_if.ram_we = wr_valid && (state == CIS_IDLE) && !fetch_valid;
         assign blk_if.wdata = fill_now ? ext_rdata : wr_data;
         assign hit_vec[g] = blk_if.hit;
         assign rd_vec[g] = blk_if.rdata;
         cis_block u_block
         (
            .ref_clk(ref_clk),
            .srst(srst),
            .ce(ce),
            .bus(blk_if)
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Fetch sequencer.
   // ------------------------------------------------------------
   // One miss at a time; the core is held off until the word is back.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state <= CIS_IDLE;
      end
      else if (ce)
      begin
         unique case (state)
            CIS_IDLE:
            begin
               if (fetch_valid && !any_hit)
               begin
                  state <= CIS_MISS;
               end
            end
            CIS_MISS:
            begin
               if (ext_ack)
               begin
                  state <= CIS_IDLE;
               end
            end
            default:
            begin
               state <= CIS_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // External bus request.
   // ------------------------------------------------------------
   // The request stays up until the bus owner answers; DMA may own the
   // bus meanwhile, which only delays misses.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         ext_req <= 1'b0;
         ext_addr <= '0;
      end
      else if (ce)
      begin
         if (take && !any_hit)
         begin
            ext_req <= 1'b1;
            ext_addr <= fetch_addr;
         end
         else if (fill_now)
         begin
            ext_req <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Response to the core.
   // ------------------------------------------------------------
   // A word is always returned on a miss, even when no way may keep it.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         resp_valid <= 1'b0;
         resp_data <= CIS_DATA_RST;
         resp_ext <= 1'b0;
      end
      else if (ce)
      begin
         resp_valid <= (take && any_hit) || fill_now;
         resp_ext <= fill_now;
         if (take && any_hit)
         begin
            resp_data <= rd_vec[hit_sel];
         end
         else if (fill_now)
         begin
            resp_data <= ext_rdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Replacement pointer.
   // ------------------------------------------------------------
   // Round robin spreads fills over the ways without per-set history;
   // it costs some hit rate against true LRU but is two flops.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         victim <= CIS_VICTIM_RST;
      end
      else if (ce && fill_now && (|fill_ok))
      begin
         victim <= fill_sel + CIS_BLK_W'(1);
      end
   end
endmodule : cis_top
`default_nettype wire

// ### common/cis_pkg.sv
`default_nettype none
package cis_pkg;
   // ------------------------------------------------------------
   // Geometry of the instruction store.
   // ------------------------------------------------------------
   localparam int CIS_NUM_BLOCKS = 4;       // Identical blocks in the store.
   localparam int CIS_ADDR_W = 32;          // System address width.
   localparam int CIS_DATA_W = 32;          // Instruction word width.
   localparam int CIS_CACHE_BYTES = 256;    // Block capacity as a cache.
   localparam int CIS_RAM_BYTES = 512;      // Block capacity as static RAM.
   localparam int CIS_WORD_BYTES = 4;       // Bytes per word.
   localparam int CIS_CACHE_ENTRIES = CIS_CACHE_BYTES / CIS_WORD_BYTES;
   localparam int CIS_RAM_WORDS = CIS_RAM_BYTES / CIS_WORD_BYTES;
   // ------------------------------------------------------------
   // Address field positions.
   // ------------------------------------------------------------
   localparam int CIS_WORD_LSB = 2;         // Lowest bit of the word index.
   localparam int CIS_CIDX_W = $clog2(CIS_CACHE_ENTRIES);
   localparam int CIS_RIDX_W = $clog2(CIS_RAM_WORDS);
   localparam int CIS_TAG_LSB = CIS_WORD_LSB + CIS_CIDX_W;
   localparam int CIS_TAG_W = CIS_ADDR_W - CIS_TAG_LSB;
   localparam int CIS_BASE_LSB = CIS_WORD_LSB + CIS_RIDX_W;
   localparam int CIS_BLK_W = $clog2(CIS_NUM_BLOCKS);
   // ------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------
   localparam logic [CIS_DATA_W-1:0] CIS_DATA_RST = 32'h0000_0000;
   localparam logic [CIS_BLK_W-1:0] CIS_VICTIM_RST = 2'h0;
   // ------------------------------------------------------------
   // Fetch sequencer states.
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      CIS_IDLE = 2'b00,   // Ready for a fetch.
      CIS_MISS = 2'b01    // Waiting for the external bus word.
   } cis_state_t;
endpackage : cis_pkg
`default_nettype wire

// ### common/cis_blk_if.sv
`default_nettype none
// ------------------------------------------------------------
// Lookup and fill path between the sequencer and one block.
// ------------------------------------------------------------
interface cis_blk_if;
   import cis_pkg::*;
   logic [CIS_ADDR_W-1:0] addr;      // Lookup or fill address.
   logic mode_ram;                   // Block acts as static RAM.
   logic lock;                       // Cache contents frozen.
   logic [CIS_ADDR_W-1:0] base;      // RAM placement base.
   logic hit;                        // Address found in this block.
   logic [CIS_DATA_W-1:0] rdata;     // Word found.
   logic fill_we;                    // Fill the cache entry at addr.
   logic ram_we;                     // Write the RAM word at addr.
   logic [CIS_DATA_W-1:0] wdata;     // Fill or write data.
   modport seq (output addr, mode_ram, lock, base, fill_we, ram_we, wdata,
                input hit, rdata);
   modport blk (input addr, mode_ram, lock, base, fill_we, ram_we, wdata,
                output hit, rdata);
endinterface : cis_blk_if
`default_nettype wire

// ### design/cis_block.sv
`default_nettype none
// ------------------------------------------------------------
// One store block: direct-mapped cache or relocatable RAM.
// ------------------------------------------------------------
module cis_block
   import cis_pkg::*;
(
   input wire logic ref_clk,   // System clock.
   input wire logic srst,      // Synchronous reset, active high.
   input wire logic ce,        // Clock enable; low freezes state.
   cis_blk_if.blk bus          // Lookup and fill path.
);
   // The same storage serves both modes; a cache uses its low half.
   logic [CIS_DATA_W-1:0] mem [CIS_RAM_WORDS];     // Word storage.
   logic [CIS_TAG_W-1:0] tag [CIS_CACHE_ENTRIES];  // Cache tags.
   logic [CIS_CACHE_ENTRIES-1:0] valid;            // Cache entry valid.
   logic [CIS_CIDX_W-1:0] cidx;                    // Cache entry index.
   logic [CIS_RIDX_W-1:0] ridx;                    // RAM word index.
   logic ram_hit;                                  // RAM window matches.
   logic cache_hit;                                // Tag matches.

   assign cidx = bus.addr[CIS_TAG_LSB-1:CIS_WORD_LSB];
   assign ridx = bus.addr[CIS_BASE_LSB-1:CIS_WORD_LSB];
   // RAM answers only in its own window at its own base.
   assign ram_hit = bus.mode_ram &&
      (bus.addr[CIS_ADDR_W-1:CIS_BASE_LSB] == bus.base[CIS_ADDR_W-1:CIS_BASE_LSB]);
   assign cache_hit = !bus.mode_ram && valid[cidx] &&
      (tag[cidx] == bus.addr[CIS_ADDR_W-1:CIS_TAG_LSB]);
   assign bus.hit = ram_hit || cache_hit;
   assign bus.rdata = bus.mode_ram ? mem[ridx] : mem[{1'b0, cidx}];

   // ------------------------------------------------------------
   // Valid bits.
   // ------------------------------------------------------------
   // Valid bits drop while the block is RAM, so stale RAM words are
   // never taken for cached code when the block turns back to cache.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         valid <= '0;
      end
      else if (ce)
      begin
         if (bus.mode_ram)
         begin
            valid <= '0;
         end
         else if (bus.fill_we && !bus.lock)
         begin
            valid[cidx] <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Word and tag storage, no reset so it maps onto RAM cells.
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (ce && !srst)
      begin
         // A locked block takes no fill at all.
         if (!bus.mode_ram && bus.fill_we && !bus.lock)
         begin
            mem[{1'b0, cidx}] <= bus.wdata;
            tag[cidx] <= bus.addr[CIS_ADDR_W-1:CIS_TAG_LSB];
         end
         else if (bus.ram_we && ram_hit)
         begin
            mem[ridx] <= bus.wdata;
         end
      end
   end
endmodule : cis_block
`default_nettype wire

// ### tb/cis_top_monitor.sv
`default_nettype none
// ------------------------------------------------------------
// Port checker for the instruction store top.
// ------------------------------------------------------------
module cis_top_monitor
   import cis_pkg::*;
(
   input wire logic ref_clk, // System clock.
   input wire logic srst, // Synchronous reset.
   input wire logic ce, // Clock enable.
   input wire logic fetch_valid, // Fetch request.
   input wire logic [cis_pkg::CIS_ADDR_W-1:0] fetch_addr, // Fetch address.
   input wire logic fetch_ready, // Fetch taken.
   input wire logic resp_valid, // Word returned.
   input wire logic [cis_pkg::CIS_DATA_W-1:0] resp_data, // Returned word.
   input wire logic resp_ext, // Word came off chip.
   input wire logic ext_req, // External read.
   input wire logic [cis_pkg::CIS_ADDR_W-1:0] ext_addr, // External address.
   input wire logic ext_ack, // External word ready.
   input wire logic [cis_pkg::CIS_DATA_W-1:0] ext_rdata // External word.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // A fetch accepted by the store.
   sequence s_take;
      ce && fetch_valid && fetch_ready;
   endsequence
   // An external word accepted by the store.
   sequence s_ack;
      ce && ext_req && ext_ack;
   endsequence
   a_take_answer: assert property (s_take |=> (resp_valid && !resp_ext) || ext_req)
      else $error("fetch got neither a hit nor a miss");
   a_miss_addr: assert property (s_take ##1 ext_req |-> ext_addr == $past(fetch_addr))
      else $error("miss address differs from fetch");
   a_miss_cause: assert property ($rose(ext_req) |-> $past(fetch_valid && fetch_ready))
      else $error("external read without a fetch");
   a_ack_return: assert property (s_ack |=> resp_valid && resp_ext && !ext_req
      && resp_data == $past(ext_rdata))
      else $error("external word not returned");
   a_miss_refuse: assert property (ext_req |-> !fetch_ready)
      else $error("fetch accepted during a miss");
   a_ext_hold: assert property (ce && ext_req && !ext_ack |=> ext_req && $stable(ext_addr))
      else $error("external read dropped early");
   a_hit_local: assert property (s_take ##1 (resp_valid && !resp_ext) |-> !ext_req)
      else $error("hit used the external bus");
   a_resp_cause: assert property (resp_valid |-> $past(fetch_valid && fetch_ready)
      || $past(ext_req && ext_ack))
      else $error("response without a cause");
   // Reset clears the returned word, so the edge just after a reset is exempt.
   a_data_hold: assert property (!resp_valid && !$past(srst) |-> $stable(resp_data))
      else $error("returned word changed between responses");
endmodule : cis_top_monitor
`default_nettype wire

// ### tb/cis_ext_model.sv
`default_nettype none
// ------------------------------------------------------------
// External bus owner: answers one read after a set wait.
// ------------------------------------------------------------
module cis_ext_model
   import cis_pkg::*;
(
   input wire logic ref_clk, // System clock.
   input wire logic srst, // Synchronous reset.
   input wire logic ext_req, // Read outstanding.
   input wire logic [cis_pkg::CIS_ADDR_W-1:0] ext_addr, // Read address.
   input wire logic [7:0] lat, // Wait cycles before the answer.
   output logic ext_ack, // Word ready pulse.
   output logic [cis_pkg::CIS_DATA_W-1:0] ext_rdata // Read word.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_cnt; // Cycles the read has waited.
   // A long wait stands for the DMA engine holding the bus.
   always_ff @(posedge ref_clk)
   begin
      if (srst || ext_ack)
      begin
         ext_ack <= 1'b0;
         wait_cnt <= 8'h00;
      end
      else if (ext_req && wait_cnt >= lat)
         ext_ack <= 1'b1;
      else if (ext_req)
         wait_cnt <= wait_cnt + 8'h01;
   end
   // Data is the inverted address on the ack, and churns otherwise so stale reads show.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         ext_rdata <= 32'h1234_5678;
      else if (ext_req && !ext_ack && wait_cnt >= lat)
         ext_rdata <= ~ext_addr;
      else
         ext_rdata <= {ext_rdata[30:0], ~ext_rdata[31]};
   end
endmodule : cis_ext_model
`default_nettype wire

// ### tb/tb_configurable_instruction_cache.sv
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t %h %h", $time, a, b); end end
module tb_configurable_instruction_cache
   import cis_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, srst, ce, fetch_valid, fetch_ready, resp_valid, resp_ext;
   logic wr_valid, ext_req, ext_ack;
   logic [CIS_NUM_BLOCKS-1:0] cfg_ram, cfg_lock;
   logic [CIS_NUM_BLOCKS*CIS_ADDR_W-1:0] cfg_base;
   logic [CIS_ADDR_W-1:0] fetch_addr, wr_addr, ext_addr;
   logic [CIS_DATA_W-1:0] resp_data, wr_data, ext_rdata;
   logic [7:0] lat; // Bus owner wait.
   int num_errors, checks_done, cycles;
   cis_top dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .cfg_ram(cfg_ram),
      .cfg_lock(cfg_lock), .cfg_base(cfg_base), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .resp_valid(resp_valid),
      .resp_data(resp_data), .resp_ext(resp_ext), .wr_valid(wr_valid), .wr_addr(wr_addr),
      .wr_data(wr_data), .ext_req(ext_req), .ext_addr(ext_addr), .ext_ack(ext_ack),
      .ext_rdata(ext_rdata));
   cis_ext_model ext_model (.ref_clk(ref_clk), .srst(srst), .ext_req(ext_req),
      .ext_addr(ext_addr), .lat(lat), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
   // ------------------------------------------------------------
   // Clock, run limit and verdict.
   // ------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // A hung handshake would otherwise stall the run forever.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   task give_verdict;
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------
   // Shared transfers.
   // ------------------------------------------------------------
   // Fetch one word and judge its source; a hit must answer one cycle after the take.
   task fetch(input logic [31:0] a, input logic [31:0] d, input logic x);
      int n;
      n = 0;
      @(posedge ref_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      #1;
      while (fetch_ready !== 1'b1)
      begin
         @(posedge ref_clk);
         #1;
      end
      // The take edge; a hit pulse stands from here to the next edge only.
      @(posedge ref_clk);
      fetch_valid <= 1'b0;
      #1;
      n = 1;
      while (resp_valid !== 1'b1 && n < 200)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (!x) `CHK(n, 1)
      `CHK(resp_data, d)
      `CHK(resp_ext, x)
   endtask : fetch
   // Load one RAM word; the fetch request is low meanwhile.
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wr_valid <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_valid <= 1'b0;
   endtask : wr
   task do_reset;
      @(posedge ref_clk);
      srst <= 1'b1;
      cfg_ram <= 4'h0;
      cfg_lock <= 4'h0;
      @(posedge ref_clk);
      srst <= 1'b0;
   endtask : do_reset
   // Addresses that share cache index 16 and differ in tag.
   function automatic logic [31:0] ta(input int k);
      return 32'h0000_0040 + 32'(k) * 32'h0000_0100;
   endfunction : ta
   // ------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------
   // Four ways fill in turn, then a fifth tag evicts the oldest way.
   task t_ways;
      do_reset();
      lat <= 8'd25;
      for (int k = 0; k < 4; k++) fetch(ta(k), ~ta(k), 1'b1);
      for (int k = 0; k < 4; k++) fetch(ta(k), ~ta(k), 1'b0);
      fetch(ta(4), ~ta(4), 1'b1);
      fetch(ta(1), ~ta(1), 1'b0);
      fetch(ta(0), ~ta(0), 1'b1);
   endtask : t_ways
   // Locked ways keep their words; with all locked a miss fills nothing.
   // Way 0 is locked just as the pointer comes back to it, so a fill
   // that ignored the lock would evict the word at 200.
   task t_lock;
      do_reset();
      lat <= 8'd0;
      fetch(32'h200, ~32'h200, 1'b1);
      fetch(32'h300, ~32'h300, 1'b1);
      fetch(32'h500, ~32'h500, 1'b1);
      fetch(32'h600, ~32'h600, 1'b1);
      @(posedge ref_clk);
      cfg_lock <= 4'h1;
      fetch(32'h400, ~32'h400, 1'b1);
      fetch(32'h200, ~32'h200, 1'b0);
      fetch(32'h300, ~32'h300, 1'b1);
      @(posedge ref_clk);
      cfg_lock <= 4'hf;
      fetch(32'h700, ~32'h700, 1'b1);
      fetch(32'h700, ~32'h700, 1'b1);
      fetch(32'h200, ~32'h200, 1'b0);
      fetch(32'h400, ~32'h400, 1'b0);
   endtask : t_lock
   // One block as RAM at its own base, both window ends, then back to cache.
   task t_ram;
      do_reset();
      @(posedge ref_clk);
      cfg_ram <= 4'h4;
      cfg_base[64+:32] <= 32'h0002_0000;
      wr(32'h0002_0000, 32'hcafe_0001);
      wr(32'h0002_01fc, 32'hcafe_01fc);
      wr(32'h0003_0000, 32'hdead_0003);
      fetch(32'h0002_0000, 32'hcafe_0001, 1'b0);
      fetch(32'h0002_01fc, 32'hcafe_01fc, 1'b0);
      fetch(32'h0002_0200, ~32'h0002_0200, 1'b1);
      fetch(32'h0003_0000, ~32'h0003_0000, 1'b1);
      @(posedge ref_clk);
      cfg_ram <= 4'h0;
      fetch(32'h0002_0000, ~32'h0002_0000, 1'b1);
   endtask : t_ram
   initial
   begin
      srst = 1'b1;
      ce = 1'b1;
      cfg_ram = 4'h0;
      cfg_lock = 4'h0;
      cfg_base = '0;
      fetch_valid = 1'b0;
      fetch_addr = 32'h0;
      wr_valid = 1'b0;
      wr_addr = 32'h0;
      wr_data = 32'h0;
      lat = 8'd3;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      t_ways();
      t_lock();
      t_ram();
      give_verdict();
   end
endmodule : tb_configurable_instruction_cache
bind cis_top cis_top_monitor mon (.ref_clk(ref_clk), .srst(srst), .ce(ce),
   .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
   .resp_valid(resp_valid), .resp_data(resp_data), .resp_ext(resp_ext), .ext_req(ext_req),
   .ext_addr(ext_addr), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
`default_nettype wire
